// >>> design/rfnd_shifter.sv
`include "rfnd_params.svh"

module rfnd_shifter (
    input wire logic clk,
    input wire logic rst,
    input wire logic ser_clk_pin,
    input wire logic ser_data_pin,
    input wire logic ser_latch_pin,
    output rfnd_pkg::rfnd_word_t word
);
    import rfnd_pkg::*;

    logic [2:0] pins;
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] prev_reg;
    assign pins = {ser_latch_pin, ser_data_pin, ser_clk_pin};

    // Each pin crosses through two flops before any use
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_sync
            always_ff @(posedge clk) begin
                if (rst) begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                    prev_reg[i] <= 1'b0;
                end else begin
                    sync1_reg[i] <= pins[i];
                    sync2_reg[i] <= sync1_reg[i];
                    prev_reg[i] <= sync2_reg[i];
                end
            end
        end
    endgenerate

    logic clk_rise;
    logic le_rise;
    assign clk_rise = sync2_reg[0] & ~prev_reg[0];
    assign le_rise = sync2_reg[2] & ~prev_reg[2];

    rfnd_state_t state_reg, state_next;
    logic [23:0] shift_reg, shift_next;
    logic [4:0] cnt_reg, cnt_next;
    rfnd_word_t word_reg, word_next;

    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        word_next = word_reg;
        word_next.valid = 1'b0;
        case (state_reg)
            RFND_ST_IDLE: begin
                if (clk_rise) begin
                    shift_next = {shift_reg[22:0], sync2_reg[1]};
                    cnt_next = 5'h01;
                    state_next = RFND_ST_SHIFT;
                end
            end
            RFND_ST_SHIFT: begin
                if (le_rise) begin
                    // Short words are dropped; longer ones keep the last 24 bits
                    if (cnt_reg == 5'(`RFND_WORD_W)) begin
                        word_next.valid = 1'b1;
                        word_next.data = shift_reg;
                    end
                    state_next = RFND_ST_IDLE;
                end else if (clk_rise) begin
                    shift_next = {shift_reg[22:0], sync2_reg[1]};
                    if (cnt_reg != 5'(`RFND_WORD_W)) begin
                        cnt_next = cnt_reg + 5'h01;
                    end
                end
            end
            default: state_next = RFND_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= RFND_ST_IDLE;
            shift_reg <= 24'h000000;
            cnt_reg <= 5'h00;
            word_reg <= '0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            word_reg <= word_next;
        end
    end

    assign word = word_reg;
endmodule

// >>> design/rfnd_top.sv
// What this block does
// - A word with bit 0 clear is the RF divider word; 23 bits are data.
// - A new divider applies after that one write, no companion write needed.
// - Every other word carries 20 data bits above a 4-bit code.
// - Fraction from bits 12..1, integer divide value from bits 23..13.
// - Integer splits 6/3/2; ratio is prescaler*coarse + 4*mid + fine.
// - Select bit clear picks 16-modulus prescaler, set picks 32-modulus.
`include "rfnd_params.svh"

module rfnd_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic ser_clk_pin,
    input wire logic ser_data_pin,
    input wire logic ser_latch_pin,
    input wire logic [4:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output rfnd_pkg::rfnd_div_t rf_divider,
    output rfnd_pkg::rfnd_split_t count_fields,
    output logic prescaler_select,
    output logic [1:0] modulator_order,
    output logic [11:0] divide_ratio,
    output logic new_freq
);
    import rfnd_pkg::*;

    rfnd_word_t word;

    rfnd_shifter u_shift (
        .clk(clk),
        .rst(rst),
        .ser_clk_pin(ser_clk_pin),
        .ser_data_pin(ser_data_pin),
        .ser_latch_pin(ser_latch_pin),
        .word(word)
    );

    logic is_div_word;
    logic is_psel_word;
    assign is_div_word = word.valid & ~word.data[`RFND_WSEL_BIT];
    assign is_psel_word = word.valid & word.data[`RFND_WSEL_BIT]
        & (word.data[`RFND_CODE_MSB:`RFND_CODE_LSB] == `RFND_PSEL_CODE);

    // Software control and captured words
    logic [2:0] ctrl_reg, ctrl_next;
    logic apply_en;
    assign apply_en = ctrl_reg[`RFND_CTRL_EN_BIT];
    assign modulator_order = ctrl_reg[`RFND_CTRL_ORD_LSB +: 2];

    rfnd_div_t div_reg, div_next;
    rfnd_split_t split_reg, split_next;
    logic psel_reg, psel_next;
    logic new_reg, new_next;
    logic [15:0] words_reg, words_next;
    logic [23:0] other_reg, other_next;
    logic [11:0] ratio_reg, ratio_next;
    logic [10:0] n_new;

    assign n_new = word.data[`RFND_INT_MSB:`RFND_INT_LSB];

    always_comb begin
        ctrl_next = ctrl_reg;
        div_next = div_reg;
        split_next = split_reg;
        psel_next = psel_reg;
        new_next = 1'b0;
        words_next = words_reg;
        other_next = other_reg;
        if (wr && addr == `RFND_A_CTRL) begin
            ctrl_next = wdata[2:0];
        end
        // Held words are dropped, not queued: software decides when to resume
        if (is_div_word && apply_en) begin
            div_next.frac = word.data[`RFND_FRAC_MSB:`RFND_FRAC_LSB];
            div_next.int_div = n_new;
            split_next.coarse = n_new[`RFND_COARSE_MSB:`RFND_COARSE_LSB];
            split_next.mid = n_new[`RFND_MID_MSB:`RFND_MID_LSB];
            split_next.fine = n_new[`RFND_FINE_MSB:`RFND_FINE_LSB];
            new_next = 1'b1;
        end
        if (word.valid && word.data[`RFND_WSEL_BIT]) begin
            other_next = word.data;
        end
        if (is_psel_word) begin
            psel_next = word.data[`RFND_PSEL_BIT];
        end
        if (word.valid) begin
            words_next = words_reg + 16'h0001;
        end
    end

    // Ratio tracks both the split and the prescaler choice
    always_comb begin
        logic [11:0] base;
        base = 12'h000;
        if (psel_reg) begin
            base = {1'b0, split_reg.coarse, 5'h00};
        end else begin
            base = {2'b00, split_reg.coarse, 4'h0};
        end
        ratio_next = base
            + {7'h00, split_reg.mid, 2'b00}
            + {10'h000, split_reg.fine};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= `RFND_CTRL_RESET;
            div_reg <= '0;
            split_reg <= '0;
            psel_reg <= 1'b0;
            new_reg <= 1'b0;
            words_reg <= 16'h0000;
            other_reg <= 24'h000000;
            ratio_reg <= 12'h000;
        end else begin
            ctrl_reg <= ctrl_next;
            div_reg <= div_next;
            split_reg <= split_next;
            psel_reg <= psel_next;
            new_reg <= new_next;
            words_reg <= words_next;
            other_reg <= other_next;
            ratio_reg <= ratio_next;
        end
    end

    // Host-side limits, checked and reported but not enforced
    logic legal;
    logic fields_ok;
    always_comb begin
        logic [10:0] n;
        // Limits bound the divide ratio; with the small prescaler it differs from the field bits
        n = ratio_reg[10:0];
        legal = 1'b0;
        fields_ok = (split_reg.coarse >= {3'h0, split_reg.mid})
            && (split_reg.coarse >= {4'h0, split_reg.fine});
        if (psel_reg) begin
            legal = (n >= `RFND_LG_MIN) && (n <= `RFND_LG_MAX);
        end else if (n < `RFND_SM_MIN) begin
            legal = 1'b0;
        end else if (n <= `RFND_SM_BAND1_HI) begin
            case (modulator_order)
                `RFND_ORD_3: legal = (n >= `RFND_SM_O3_LO) && (n <= `RFND_SM_O3_HI);
                `RFND_ORD_4: legal = (n == `RFND_SM_O4_ONLY);
                default: legal = (n <= `RFND_SM_O2_HI);
            endcase
        end else if (n <= `RFND_SM_BAND2_HI) begin
            if (modulator_order == `RFND_ORD_4) begin
                legal = (n <= `RFND_SM_O4B2_HI);
            end else begin
                legal = 1'b1;
            end
        end else begin
            legal = (n <= `RFND_SM_MAX);
        end
    end

    // Register read path, data one cycle after the strobe
    logic [31:0] rdata_reg, rdata_next;
    always_comb begin
        rdata_next = 32'h00000000;
        if (rd) begin
            case (addr)
                `RFND_A_CTRL: rdata_next = {29'h0, ctrl_reg};
                `RFND_A_DIV: rdata_next = {8'h00, psel_reg, div_reg};
                `RFND_A_SPLIT: rdata_next = {9'h000, ratio_reg, split_reg};
                `RFND_A_STAT: rdata_next = {14'h0000, fields_ok, legal, words_reg};
                `RFND_A_OTHER: rdata_next = {8'h00, other_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign rf_divider = div_reg;
    assign count_fields = split_reg;
    assign prescaler_select = psel_reg;
    assign divide_ratio = ratio_reg;
    assign new_freq = new_reg;

    word_select_a: assert property (@(posedge clk) disable iff (rst)
        word.valid && word.data[`RFND_WSEL_BIT] |=> $stable(div_reg))
        else $error("divider changed on a word with bit 0 set");

    single_write_a: assert property (@(posedge clk) disable iff (rst)
        is_div_word && apply_en |=> new_freq ##1 !new_freq)
        else $error("divider word did not apply in one write");

    other_word_a: assert property (@(posedge clk) disable iff (rst)
        word.valid && word.data[`RFND_WSEL_BIT]
        |=> other_reg == $past(word.data))
        else $error("other word not captured");

    frac_int_a: assert property (@(posedge clk) disable iff (rst)
        is_div_word && apply_en
        |=> rf_divider.frac == $past(word.data[`RFND_FRAC_MSB:`RFND_FRAC_LSB])
        && rf_divider.int_div == $past(word.data[`RFND_INT_MSB:`RFND_INT_LSB]))
        else $error("fraction or integer field misplaced");

    ratio_split_a: assert property (@(posedge clk) disable iff (rst)
        new_freq |=> divide_ratio == 12'(count_fields.coarse)
        * (prescaler_select ? 12'h020 : 12'h010)
        + 12'(count_fields.mid) * 12'h004 + 12'(count_fields.fine))
        else $error("divide ratio does not match fields");

    prescaler_a: assert property (@(posedge clk) disable iff (rst)
        is_psel_word |=> prescaler_select == $past(word.data[`RFND_PSEL_BIT])
        ##1 ($stable(prescaler_select) || $past(is_psel_word)))
        else $error("prescaler select not taken");
endmodule

// >>> shared/rfnd_params.svh
`ifndef RFND_PARAMS_SVH
`define RFND_PARAMS_SVH

// Serial word layout
`define RFND_WORD_W 24
`define RFND_WSEL_BIT 0
`define RFND_FRAC_LSB 1
`define RFND_FRAC_MSB 12
`define RFND_INT_LSB 13
`define RFND_INT_MSB 23
`define RFND_CODE_MSB 3
`define RFND_CODE_LSB 0
`define RFND_DATA_LSB 4
`define RFND_DATA_MSB 23
`define RFND_PSEL_BIT 22
`define RFND_PSEL_CODE 4'h3

// Integer value split
`define RFND_COARSE_MSB 10
`define RFND_COARSE_LSB 5
`define RFND_MID_MSB 4
`define RFND_MID_LSB 2
`define RFND_FINE_MSB 1
`define RFND_FINE_LSB 0
`define RFND_MID_WEIGHT_SHIFT 2

// Local register bus map
`define RFND_ADDR_W 5
`define RFND_A_CTRL 5'h00
`define RFND_A_DIV 5'h04
`define RFND_A_SPLIT 5'h08
`define RFND_A_STAT 5'h0c
`define RFND_A_OTHER 5'h10
`define RFND_CTRL_RESET 3'h3
`define RFND_CTRL_EN_BIT 0
`define RFND_CTRL_ORD_LSB 1

// Modulator order codes
`define RFND_ORD_2 2'h1
`define RFND_ORD_3 2'h2
`define RFND_ORD_4 2'h3

// Legal integer windows
`define RFND_SM_MIN 11'h031
`define RFND_SM_BAND1_HI 11'h03f
`define RFND_SM_O2_HI 11'h03d
`define RFND_SM_O3_LO 11'h033
`define RFND_SM_O3_HI 11'h03b
`define RFND_SM_O4_ONLY 11'h037
`define RFND_SM_BAND2_HI 11'h04f
`define RFND_SM_O4B2_HI 11'h04b
`define RFND_SM_MAX 11'h3ff
`define RFND_LG_MIN 11'h061
`define RFND_LG_MAX 11'h7fd

`endif

// >>> shared/rfnd_pkg.sv
package rfnd_pkg;
    typedef struct packed {
        logic [10:0] int_div;
        logic [11:0] frac;
    } rfnd_div_t;

    typedef struct packed {
        logic [5:0] coarse;
        logic [2:0] mid;
        logic [1:0] fine;
    } rfnd_split_t;

    typedef struct packed {
        logic valid;
        logic [23:0] data;
    } rfnd_word_t;

    typedef enum logic [1:0] {
        RFND_ST_IDLE = 2'b01,
        RFND_ST_SHIFT = 2'b10
    } rfnd_state_t;
endpackage

// >>> tb/rfnd_host_model.sv
module rfnd_host_model (
    input wire logic clk,
    output logic ser_clk_pin,
    output logic ser_data_pin,
    output logic ser_latch_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ser_clk_pin = 1'b0;
        ser_data_pin = 1'b0;
        ser_latch_pin = 1'b0;
    end

    // Call just after a rising clk; levels held 3 cycles so the sync never misses one
    task automatic send(input logic [23:0] w, input int nbits);
        for (int i = nbits - 1; i >= 0; i--) begin
            ser_data_pin <= w[i];
            repeat (3) @(posedge clk);
            ser_clk_pin <= 1'b1;
            repeat (3) @(posedge clk);
            ser_clk_pin <= 1'b0;
        end
        // Released data line must not keep showing the last bit
        ser_data_pin <= ~ser_data_pin;
        repeat (3) @(posedge clk);
        ser_latch_pin <= 1'b1;
        repeat (3) @(posedge clk);
        ser_latch_pin <= 1'b0;
    endtask
endmodule

// >>> tb/rfnd_top_tb.sv
module rfnd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rfnd_pkg::*;

    logic clk, rst, wr, rd, prescaler_select, new_freq, sck, sdi, sle;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, rv, lfsr;
    logic [1:0] modulator_order;
    logic [11:0] divide_ratio;
    rfnd_div_t rf_divider;
    rfnd_split_t count_fields;
    int n_mismatch = 0;
    int n_checks = 0;
    int psel = 0;
    int n_words = 0;
    int exp_q[$];
    int fixed_n[8] = '{49, 51, 55, 64, 75, 79, 80, 1023};
    int fixed_o[8] = '{1, 2, 3, 3, 3, 2, 1, 3};

    rfnd_top rfnd_top_i (.clk(clk), .rst(rst), .ser_clk_pin(sck), .ser_data_pin(sdi),
        .ser_latch_pin(sle), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rf_divider(rf_divider), .count_fields(count_fields),
        .prescaler_select(prescaler_select), .modulator_order(modulator_order),
        .divide_ratio(divide_ratio), .new_freq(new_freq));
    rfnd_host_model rfnd_host_model_i (.clk(clk), .ser_clk_pin(sck), .ser_data_pin(sdi),
        .ser_latch_pin(sle));

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Host packs the ratio into coarse/mid/fine so coarse covers both smaller fields
    function automatic logic [10:0] enc(input int n, input int p);
        if (p != 0) return 11'(n);
        return {6'(n / 16), 3'(n % 16 / 4), 2'(n % 4)};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // w=1 write, w=0 read; read data lands in rv
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 rv = rdata;
    endtask

    task automatic send_div(input int n, input int f, input int nbits, input int keep);
        int seen;
        int e;
        logic [10:0] fld;
        fld = enc(n, psel);
        @(posedge clk);
        rfnd_host_model_i.send({fld, f[11:0], 1'b0}, nbits);
        if (nbits == 24) n_words++;
        seen = 0;
        for (int i = 0; i < 20 && seen == 0; i++) begin
            @(posedge clk);
            #1 if (new_freq === 1'b1) seen = 1;
        end
        check(seen, keep);
        if (keep != 0) exp_q.push_back(32'({fld, f[11:0]}));
        e = exp_q[$];
        check(rf_divider, e[22:0]);
        check(count_fields, {e[22:17], e[16:14], e[13:12]});
        @(posedge clk);
        #1 check(divide_ratio,
            12'((psel ? 32 : 16) * e[22:17] + 4 * e[16:14] + e[13:12]));
        if (keep != 0) check(divide_ratio, 12'(n));
        bus(1'b0, 5'h04, 32'h0);
        check(rv & 32'h007fffff, e[22:0]);
    endtask

    task automatic send_other(input int p);
        logic [23:0] w;
        w = {1'b0, p[0], 18'h0, 4'h3};
        @(posedge clk);
        rfnd_host_model_i.send(w, 24);
        n_words++;
        psel = p;
        repeat (8) @(posedge clk);
        #1 check(prescaler_select, p);
        bus(1'b0, 5'h10, 32'h0);
        check(rv, w);
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish;
    end

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 5'h00;
        wdata = 32'h0;
        lfsr = 32'h0f64a447;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 check(new_freq, 0);
        check(modulator_order, 1);
        check(rf_divider, 0);
        $display("test reset done");
        // Legal boundaries of each band, each with its modulator order
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 5'h00, 32'(fixed_o[i] * 2 + 1));
            @(posedge clk);
            #1 check(modulator_order, fixed_o[i]);
            send_div(fixed_n[i], i * 291, 24, 1);
            bus(1'b0, 5'h0c, 32'h0);
            check(rv[17:16], 2'h3);
        end
        $display("test band boundaries done");
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            send_div(80 + lfsr % 944, lfsr[27:16], 24, 1);
        end
        $display("test random words done");
        send_other(1);
        lfsr = lfsr_next(lfsr);
        // Large prescaler: coarse of at least 8 keeps it above mid and fine
        send_div(256 + lfsr % 768, lfsr[27:16], 24, 1);
        send_other(0);
        $display("test prescaler select done");
        // Short word and disabled apply must both leave the divider alone
        send_div(300, 7, 20, 0);
        bus(1'b1, 5'h00, 32'h2);
        send_div(301, 8, 24, 0);
        bus(1'b1, 5'h00, 32'h3);
        send_div(302, 9, 24, 1);
        $display("test dropped words done");
        bus(1'b1, 5'h04, 32'hffffffff);
        bus(1'b0, 5'h04, 32'h0);
        check(rv & 32'h007fffff, {enc(302, 0), 12'h009});
        bus(1'b0, 5'h14, 32'h0);
        check(rv, 0);
        bus(1'b0, 5'h00, 32'h0);
        check(rv[2:0], 3'h3);
        bus(1'b0, 5'h0c, 32'h0);
        check(rv[15:0], n_words);
        $display("test register bus done");
        tally_and_finish;
    end
endmodule
